// ### sfeg_erase_guard.sv
// erase, write latch and sector protection sequencer of a spi flash
// assumes an array that erases on request and streams back verify bytes
//
// Functional notes
// - opcode picks 4K, 32K or 64K block
// - erased bytes must all read as ones
// - guarded commands need write latch already set
// - opcode, three address bytes; erase at release
// - low address bits ignored per erase size
// - short address or misaligned release aborts erase
// - protected target: skip erase, back to idle
// - multi-sector erase needs whole span unprotected
// - aborted or protected block erase clears latch
// - busy while erasing; latch cleared before end
// - failed erase verify sets error flag
// - chip erase opcodes 60h, C7h, erase at release
// - incomplete chip erase opcode: no erase
// - any protected sector blocks chip erase, clears latch
// - write enable 06h sets latch at release
// - bad enable or disable frame leaves latch
// - write disable 04h clears latch at release
// - write disable ends sequential program mode
// - one protect bit per sector, reset protected
// - protect sets bit; zero allows erase
// - protect 36h plus address, clears latch
// - unprotect 39h plus address, clears bit, latch
`timescale 1ns/1ps
module sfeg_erase_guard import sfeg_pkg::*; #(
	parameter int unsigned BLOCK_ERASE_CYCLES = BLOCK_ERASE_CYCLES_DEF,
	parameter int unsigned CHIP_ERASE_CYCLES = CHIP_ERASE_CYCLES_DEF
) (
	// core clock and reset
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	// spi pins, link clock
	input wire logic spi_sclk_i,
	input wire logic spi_cs_n_i,
	input wire logic spi_mosi_i,
	output logic spi_miso_o,
	output logic spi_miso_oe_n_o,
	// array erase request
	output logic erase_start_o,
	output sfeg_erase_type erase_req_o,
	output logic [7:0] erase_fill_o,
	// array erase verify stream
	input wire logic verify_valid_i,
	input wire logic [7:0] verify_data_i,
	// status and protection state
	output logic busy_o,
	output logic write_latch_flag_o,
	output logic erase_program_error_flag_o,
	output logic [NUM_SECT-1:0] sector_prot_o,
	output logic seq_prog_exit_o
);

	// ----------------------------------------------------------------
	// sector helpers
	// ----------------------------------------------------------------
	// table lookup, any range
	function automatic logic [NUM_SECT-1:0] span_mask(
		input logic [ADDR_W-1:0] lo,
		input logic [ADDR_W-1:0] hi
	);
		logic [NUM_SECT-1:0] m;
		m = '0;
		for (int i = 0; i < NUM_SECT; i++) begin
			m[i] = (SECT_EDGE[i] <= {1'b0, hi}) &&
				(SECT_EDGE[i+1] > {1'b0, lo});
		end
		return m;
	endfunction : span_mask

	function automatic logic [ADDR_W-1:0] low_mask(input sfeg_size_type sz);
		logic [ADDR_W-1:0] m;
		m = '1;
		unique case (sz)
			SZ_4K: m = ADDR_W'((1 << IGN_4K) - 1);
			SZ_32K: m = ADDR_W'((1 << IGN_32K) - 1);
			SZ_64K: m = ADDR_W'((1 << IGN_64K) - 1);
			SZ_CHIP: m = '1;
		endcase
		return m;
	endfunction : low_mask

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_ERASE = 2'b10
	} sfeg_state_type;

	sfeg_state_type state_r;
	sfeg_state_type state_nxt;
	sfeg_frame_type frame;
	logic cs_s1_r;
	logic cs_s2_r;
	logic cs_d_r;
	logic cs_rise;
	logic wlf_r;
	logic epe_r;
	logic [NUM_SECT-1:0] prot_r;
	logic [31:0] timer_r;
	logic erase_start_r;
	sfeg_erase_type erase_req_r;
	logic [7:0] erase_fill_r;
	logic seq_exit_r;
	logic [7:0] status_r;
	logic [7:0] status_nxt;

	// decoded frame
	logic op_v;
	logic aligned;
	logic op_ok;
	logic addr_ok;
	logic is_blk;
	logic is_chip;
	logic is_prot;
	logic is_unprot;
	logic is_wren;
	logic is_wrdi;
	logic idle_rise;
	logic gated;
	sfeg_size_type blk_size;
	logic [ADDR_W-1:0] addr_lo;
	logic [ADDR_W-1:0] blk_base;
	logic [ADDR_W-1:0] blk_last;
	logic [NUM_SECT-1:0] blk_span;
	logic [NUM_SECT-1:0] one_sect;
	logic blk_hit;
	logic do_wren;
	logic do_wrdi;
	logic blk_go;
	logic blk_drop;
	logic chip_go;
	logic chip_drop;
	logic sp_go;
	logic sp_drop;
	logic erase_go;
	logic erase_done;

	// ----------------------------------------------------------------
	// spi link domain
	// ----------------------------------------------------------------
	sfeg_spi_frame u_frame (
		.spi_sclk_i(spi_sclk_i),
		.spi_cs_n_i(spi_cs_n_i),
		.spi_mosi_i(spi_mosi_i),
		.reset_n_i(reset_n_i),
		.status_i(status_r),
		.frame_o(frame),
		.miso_o(spi_miso_o),
		.miso_oe_n_o(spi_miso_oe_n_o)
	);

	// ----------------------------------------------------------------
	// chip select crossing
	// ----------------------------------------------------------------
	// frame fields are static once cs is high, so the synced rise
	// qualifies them; no per-bit synchroniser needed
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cs_s1_r <= 1'b1;
			cs_s2_r <= 1'b1;
			cs_d_r <= 1'b1;
		end else begin
			cs_s1_r <= spi_cs_n_i;
			cs_s2_r <= cs_s1_r;
			cs_d_r <= cs_s2_r;
		end
	end

	assign cs_rise = cs_s2_r & ~cs_d_r;

	// ----------------------------------------------------------------
	// command decode at release
	// ----------------------------------------------------------------
	// byte boundary check
	assign aligned = frame.bits == 3'd0;
	assign op_v = frame.bytes != 3'd0;
	assign op_ok = aligned & op_v;
	assign addr_ok = aligned & (frame.bytes >= ADDR_BYTES_DONE);

	assign is_blk = op_v & ((frame.opcode == OP_ERASE_4K) |
		(frame.opcode == OP_ERASE_32K) | (frame.opcode == OP_ERASE_64K));
	assign is_chip = op_v & ((frame.opcode == OP_CHIP_A) |
		(frame.opcode == OP_CHIP_B));
	assign is_prot = op_v & (frame.opcode == OP_PROTECT);
	assign is_unprot = op_v & (frame.opcode == OP_UNPROTECT);
	assign is_wren = op_v & (frame.opcode == OP_WR_ENABLE);
	assign is_wrdi = op_v & (frame.opcode == OP_WR_DISABLE);

	always_comb begin
		blk_size = SZ_4K;
		unique case (frame.opcode)
			OP_ERASE_32K: blk_size = SZ_32K;
			OP_ERASE_64K: blk_size = SZ_64K;
			default: blk_size = SZ_4K;
		endcase
	end

	assign addr_lo = frame.addr[ADDR_W-1:0];
	assign blk_base = addr_lo & ~low_mask(blk_size);
	assign blk_last = blk_base | low_mask(blk_size);
	assign blk_span = span_mask(blk_base, blk_last);
	assign one_sect = span_mask(addr_lo, addr_lo);
	assign blk_hit = |(blk_span & prot_r);

	// nothing but status reads while busy
	assign idle_rise = cs_rise & (state_r == ST_IDLE);
	assign gated = idle_rise & wlf_r;

	assign do_wren = idle_rise & is_wren & op_ok;
	assign do_wrdi = idle_rise & is_wrdi & op_ok;
	assign blk_go = gated & is_blk & addr_ok & ~blk_hit;
	// abort and protection both drop latch
	assign blk_drop = gated & is_blk & (~addr_ok | blk_hit);
	assign chip_go = gated & is_chip & op_ok & ~|prot_r;
	assign chip_drop = gated & is_chip & op_ok & |prot_r;
	assign sp_go = gated & (is_prot | is_unprot) & addr_ok;
	assign sp_drop = gated & (is_prot | is_unprot) & ~addr_ok;
	assign erase_go = blk_go | chip_go;

	// ----------------------------------------------------------------
	// write latch flag
	// ----------------------------------------------------------------
	// bad enable or disable frames fall through unchanged
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wlf_r <= 1'b0;
		end else if (do_wren) begin
			wlf_r <= 1'b1;
		end else if (do_wrdi | blk_drop | chip_drop | sp_go | sp_drop) begin
			wlf_r <= 1'b0;
		end else if (erase_go) begin
			wlf_r <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// sector protection bits
	// ----------------------------------------------------------------
	// all protected out of reset
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			prot_r <= SECT_PROT_RESET;
		end else if (sp_go && is_prot) begin
			prot_r <= prot_r | one_sect;
		end else if (sp_go && is_unprot) begin
			prot_r <= prot_r & ~one_sect;
		end
	end

	// ----------------------------------------------------------------
	// sequential program exit
	// ----------------------------------------------------------------
	// pulse to the program sequencer
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			seq_exit_r <= 1'b0;
		end else begin
			seq_exit_r <= do_wrdi;
		end
	end

	// ----------------------------------------------------------------
	// erase sequencer
	// ----------------------------------------------------------------
	assign erase_done = (state_r == ST_ERASE) && (timer_r == 32'd0);

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_IDLE: begin
				if (erase_go) begin
					state_nxt = ST_ERASE;
				end
			end
			ST_ERASE: begin
				if (erase_done) begin
					state_nxt = ST_IDLE;
				end
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_r <= ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// self-timed duration; the array gets no done of its own
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			timer_r <= 32'd0;
		end else if (blk_go) begin
			timer_r <= BLOCK_ERASE_CYCLES - 32'd1;
		end else if (chip_go) begin
			timer_r <= CHIP_ERASE_CYCLES - 32'd1;
		end else if (state_r == ST_ERASE && timer_r != 32'd0) begin
			timer_r <= timer_r - 32'd1;
		end
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			erase_start_r <= 1'b0;
			erase_req_r <= '{size: SZ_4K, base: '0};
			erase_fill_r <= ERASED_BYTE;
		end else begin
			erase_start_r <= erase_go;
			erase_fill_r <= ERASED_BYTE;
			if (blk_go) begin
				erase_req_r <= '{size: blk_size, base: blk_base};
			end else if (chip_go) begin
				erase_req_r <= '{size: SZ_CHIP, base: '0};
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			epe_r <= 1'b0;
		end else if (state_r == ST_ERASE && verify_valid_i &&
			verify_data_i != ERASED_BYTE) begin
			epe_r <= 1'b1;
		end else if (erase_go) begin
			epe_r <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// status byte
	// ----------------------------------------------------------------
	// busy reported throughout
	always_comb begin
		status_nxt = 8'h00;
		status_nxt[STAT_BUSY] = state_r == ST_ERASE;
		status_nxt[STAT_WLF] = wlf_r;
		status_nxt[STAT_EPE] = epe_r;
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			status_r <= 8'h00;
		end else begin
			status_r <= status_nxt;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign erase_start_o = erase_start_r;
	assign erase_req_o = erase_req_r;
	assign erase_fill_o = erase_fill_r;
	assign busy_o = status_r[STAT_BUSY];
	assign write_latch_flag_o = status_r[STAT_WLF];
	assign erase_program_error_flag_o = status_r[STAT_EPE];
	assign sector_prot_o = prot_r;
	assign seq_prog_exit_o = seq_exit_r;

endmodule : sfeg_erase_guard

// ### sfeg_pkg.sv
// constants, opcodes, sector table and carrier types for the erase guard
// assumes a 250 MHz core clock and a 512 Kbyte array behind the block
package sfeg_pkg;

	// ----------------------------------------------------------------
	// array geometry and sector table
	// ----------------------------------------------------------------
	localparam int ADDR_W = 19;
	localparam int NUM_SECT = 11;
	// sector edges, one past the last entry is the array size
	localparam logic [NUM_SECT:0][ADDR_W:0] SECT_EDGE = {
		20'h80000, 20'h7c000, 20'h7a000, 20'h78000,
		20'h70000, 20'h60000, 20'h50000, 20'h40000,
		20'h30000, 20'h20000, 20'h10000, 20'h00000
	};
	localparam logic [NUM_SECT-1:0] SECT_PROT_RESET = {NUM_SECT{1'b1}};

	// low address bits ignored per erase size
	localparam int IGN_4K = 12;
	localparam int IGN_32K = 15;
	localparam int IGN_64K = 16;

	// ----------------------------------------------------------------
	// opcodes
	// ----------------------------------------------------------------
	localparam logic [7:0] OP_ERASE_4K = 8'h20;
	localparam logic [7:0] OP_ERASE_32K = 8'h52;
	localparam logic [7:0] OP_ERASE_64K = 8'hd8;
	localparam logic [7:0] OP_CHIP_A = 8'h60;
	localparam logic [7:0] OP_CHIP_B = 8'hc7;
	localparam logic [7:0] OP_WR_ENABLE = 8'h06;
	localparam logic [7:0] OP_WR_DISABLE = 8'h04;
	localparam logic [7:0] OP_PROTECT = 8'h36;
	localparam logic [7:0] OP_UNPROTECT = 8'h39;
	localparam logic [7:0] OP_READ_STATUS = 8'h05;

	// ----------------------------------------------------------------
	// status byte layout and erased value
	// ----------------------------------------------------------------
	localparam int STAT_BUSY = 0;
	localparam int STAT_WLF = 1;
	localparam int STAT_EPE = 5;
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	localparam logic [2:0] ADDR_BYTES_DONE = 3'd4;
	localparam logic [2:0] BYTES_SAT = 3'd7;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 250;
	localparam int BLOCK_ERASE_DURATION_US = 1000;
	localparam int CHIP_ERASE_DURATION_US = 8000;
	localparam int BLOCK_ERASE_CYCLES_DEF = BLOCK_ERASE_DURATION_US * CLK_MHZ;
	localparam int CHIP_ERASE_CYCLES_DEF = CHIP_ERASE_DURATION_US * CLK_MHZ;

	// ----------------------------------------------------------------
	// carrier types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SZ_4K = 2'd0,
		SZ_32K = 2'd1,
		SZ_64K = 2'd2,
		SZ_CHIP = 2'd3
	} sfeg_size_type;

	typedef struct packed {
		logic [7:0] opcode;
		logic [23:0] addr;
		logic [2:0] bytes;
		logic [2:0] bits;
	} sfeg_frame_type;

	typedef struct packed {
		sfeg_size_type size;
		logic [ADDR_W-1:0] base;
	} sfeg_erase_type;

endpackage : sfeg_pkg

// ### sfeg_spi_frame.sv
// spi link side: shifts in one frame, holds it after chip select rises
// assumes mode 0 or 3 and a host that pauses a few core cycles between frames
`timescale 1ns/1ps
module sfeg_spi_frame import sfeg_pkg::*; (
	// link clock and pins
	input wire logic spi_sclk_i,
	input wire logic spi_cs_n_i,
	input wire logic spi_mosi_i,
	input wire logic reset_n_i,
	// status from core domain
	input wire logic [7:0] status_i,
	// frame to core domain and serial out
	output sfeg_frame_type frame_o,
	output logic miso_o,
	output logic miso_oe_n_o
);

	logic link_rst;
	logic fresh_r;
	logic [2:0] bit_r;
	logic [2:0] bytes_r;
	logic [6:0] shift_r;
	logic [7:0] opcode_r;
	logic [23:0] addr_r;
	logic [7:0] stat_s1_r;
	logic [7:0] stat_s2_r;
	logic drive_r;
	logic miso_r;
	logic [2:0] bit_cur;
	logic [2:0] bytes_cur;

	// ----------------------------------------------------------------
	// frame start marker
	// ----------------------------------------------------------------
	// sclk idles between frames, so a new frame is seen on its first edge
	assign link_rst = spi_cs_n_i | ~reset_n_i;

	always_ff @(posedge spi_sclk_i or posedge link_rst) begin
		if (link_rst) begin
			fresh_r <= 1'b1;
		end else begin
			fresh_r <= 1'b0;
		end
	end

	assign bit_cur = fresh_r ? 3'd0 : bit_r;
	assign bytes_cur = fresh_r ? 3'd0 : bytes_r;

	// ----------------------------------------------------------------
	// shifter and byte capture
	// ----------------------------------------------------------------
	// frame stays held after cs rises until the next frame's first edge
	always_ff @(posedge spi_sclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			bit_r <= 3'd0;
			bytes_r <= 3'd0;
			shift_r <= 7'h00;
			opcode_r <= 8'h00;
			addr_r <= 24'h000000;
		end else begin
			bit_r <= bit_cur + 3'd1;
			shift_r <= {shift_r[5:0], spi_mosi_i};
			bytes_r <= bytes_cur;
			if (bit_cur == 3'd7) begin
				if (bytes_cur != BYTES_SAT) begin
					bytes_r <= bytes_cur + 3'd1;
				end
				if (bytes_cur == 3'd0) begin
					opcode_r <= {shift_r, spi_mosi_i};
				end else if (bytes_cur < ADDR_BYTES_DONE) begin
					addr_r <= {addr_r[15:0], shift_r, spi_mosi_i};
				end
			end
		end
	end

	assign frame_o = '{opcode: opcode_r, addr: addr_r,
		bytes: bytes_r, bits: bit_r};

	// ----------------------------------------------------------------
	// status readout
	// ----------------------------------------------------------------
	always_ff @(posedge spi_sclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			stat_s1_r <= 8'h00;
			stat_s2_r <= 8'h00;
		end else begin
			stat_s1_r <= status_i;
			stat_s2_r <= stat_s1_r;
		end
	end

	always_ff @(negedge spi_sclk_i or posedge link_rst) begin
		if (link_rst) begin
			drive_r <= 1'b0;
			miso_r <= 1'b0;
		end else begin
			drive_r <= (bytes_r != 3'd0) && (opcode_r == OP_READ_STATUS);
			miso_r <= stat_s2_r[3'd7 - bit_r];
		end
	end

	assign miso_o = miso_r;
	assign miso_oe_n_o = spi_cs_n_i | fresh_r | ~drive_r;

endmodule : sfeg_spi_frame

// ### sfeg_erase_guard_asserts.sv
// concurrent checks on the ports of the erase guard
// assumes a bind onto sfeg_erase_guard, handing on both erase counts
`timescale 1ns/1ps
module sfeg_erase_guard_asserts import sfeg_pkg::*; #(
	parameter int unsigned BLOCK_ERASE_CYCLES = 20,
	parameter int unsigned CHIP_ERASE_CYCLES = 40
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	// array side
	input wire logic erase_start_o,
	input wire sfeg_erase_type erase_req_o,
	input wire logic [7:0] erase_fill_o,
	input wire logic verify_valid_i,
	input wire logic [7:0] verify_data_i,
	// status and protection
	input wire logic busy_o,
	input wire logic write_latch_flag_o,
	input wire logic erase_program_error_flag_o,
	input wire logic [NUM_SECT-1:0] sector_prot_o,
	input wire logic seq_prog_exit_o
);
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!reset_n_i);

	// ----------------------------------------------------------------
	// busy length bookkeeping
	// ----------------------------------------------------------------
	int unsigned busy_cnt_r;
	logic chip_r;
	int unsigned exp_len;
	assign exp_len = chip_r ? CHIP_ERASE_CYCLES : BLOCK_ERASE_CYCLES;
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			busy_cnt_r <= 0;
		end else begin
			busy_cnt_r <= busy_o ? busy_cnt_r + 1 : 0;
		end
	end
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			chip_r <= 1'b0;
		end else if (erase_start_o) begin
			chip_r <= erase_req_o.size == SZ_CHIP;
		end
	end

	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	sequence s_launch;
		(write_latch_flag_o && !busy_o) ##1 (busy_o && !write_latch_flag_o);
	endsequence
	sequence s_hold;
		busy_o [*8];
	endsequence
	a_start_guarded: assert property (erase_start_o |-> s_launch)
		else $error("erase launched without latch or while busy");
	a_busy_holds: assert property (erase_start_o |=> s_hold)
		else $error("busy did not hold after erase start");
	a_fill_ones: assert property (erase_fill_o == ERASED_BYTE)
		else $error("erase fill value is not all ones");
	a_base_aligned: assert property (
		erase_start_o && erase_req_o.size != SZ_CHIP |->
		(erase_req_o.base & (erase_req_o.size == SZ_4K ? 19'h00fff :
		erase_req_o.size == SZ_32K ? 19'h07fff : 19'h0ffff)) == 19'h0)
		else $error("erase base keeps ignored address bits");
	a_chip_unprotected: assert property (
		erase_start_o && erase_req_o.size == SZ_CHIP |-> sector_prot_o == '0)
		else $error("chip erase launched with a protected sector");
	// one cycle of slack either way for the sync stages
	a_busy_length: assert property ($fell(busy_o) |->
		busy_cnt_r + 1 >= exp_len && busy_cnt_r <= exp_len + 1)
		else $error("busy length differs from erase duration");
	a_verify_error: assert property (
		busy_o && verify_valid_i && verify_data_i != ERASED_BYTE |->
		##[1:3] erase_program_error_flag_o)
		else $error("failed verify byte did not raise error flag");
	a_exit_clears: assert property (seq_prog_exit_o |=>
		!seq_prog_exit_o && !write_latch_flag_o)
		else $error("write disable pulse or latch clear wrong");
	a_prot_quiet: assert property ($changed(sector_prot_o) |-> !busy_o)
		else $error("protection changed while busy");
endmodule : sfeg_erase_guard_asserts

bind sfeg_erase_guard sfeg_erase_guard_asserts #(
	.BLOCK_ERASE_CYCLES(BLOCK_ERASE_CYCLES),
	.CHIP_ERASE_CYCLES(CHIP_ERASE_CYCLES)
) chk (
	.core_clk_i(core_clk_i),
	.reset_n_i(reset_n_i),
	.erase_start_o(erase_start_o),
	.erase_req_o(erase_req_o),
	.erase_fill_o(erase_fill_o),
	.verify_valid_i(verify_valid_i),
	.verify_data_i(verify_data_i),
	.busy_o(busy_o),
	.write_latch_flag_o(write_latch_flag_o),
	.erase_program_error_flag_o(erase_program_error_flag_o),
	.sector_prot_o(sector_prot_o),
	.seq_prog_exit_o(seq_prog_exit_o)
);

// ### sfeg_host_model.sv
// behavioural spi host that frames commands toward the erase guard
// assumes the bench calls xfer and leaves it alone between frames
`timescale 1ns/1ps
module sfeg_host_model (
	// spi pins
	output logic spi_sclk_o,
	output logic spi_cs_n_o,
	output logic spi_mosi_o,
	input wire logic spi_miso_i,
	input wire logic spi_miso_oe_n_i
);
	initial begin
		spi_sclk_o = 1'b0;
		spi_cs_n_o = 1'b1;
		spi_mosi_o = 1'b0;
	end

	// ----------------------------------------------------------------
	// one frame, 6 ns link clock, still between frames
	// ----------------------------------------------------------------
	task automatic xfer(input logic [39:0] d, input int nb,
		output logic [7:0] rd);
		rd = 8'h00;
		spi_cs_n_o = 1'b0;
		#5;
		for (int i = 0; i < nb; i++) begin
			spi_mosi_o = d[39-i];
			#3 spi_sclk_o = 1'b1;
			if (i >= 8 && i < 16) begin
				rd = {rd[6:0], spi_miso_oe_n_i ? ~rd[0] : spi_miso_i};
			end
			#3 spi_sclk_o = 1'b0;
		end
		#4 spi_cs_n_o = 1'b1;
		// released line flips so a stale level never passes for data
		spi_mosi_o = ~spi_mosi_o;
		// gap well above four core cycles
		#40;
	endtask : xfer
endmodule : sfeg_host_model

// ### sfeg_erase_guard_bench.sv
// self-checking bench for the erase guard with a behavioural spi host
// assumes the package, host model and bound checker are compiled first
`timescale 1ns/1ps
module sfeg_erase_guard_bench import sfeg_pkg::*;;
`define CHK(nm, ex, ac) begin \
	tests_run++; \
	if ((ac) !== (ex)) begin \
		num_errors++; \
		$display("MISMATCH %s exp %0h got %0h", nm, ex, ac); \
	end \
end
	// short erase times keep the run brief
	localparam int BLK = 200;
	localparam int CHP = 400;
	logic core_clk_i, reset_n_i, spi_sclk_i, spi_cs_n_i, spi_mosi_i;
	logic spi_miso_o, spi_miso_oe_n_o, erase_start_o, busy_o;
	logic write_latch_flag_o, erase_program_error_flag_o, seq_prog_exit_o;
	logic verify_valid_i;
	logic [7:0] verify_data_i, erase_fill_o;
	logic [NUM_SECT-1:0] sector_prot_o;
	sfeg_erase_type erase_req_o, last_req;
	int num_errors, tests_run, starts, exits;

	initial begin
		core_clk_i = 1'b0;
		forever #2 core_clk_i = ~core_clk_i;
	end
	sfeg_host_model host (
		.spi_sclk_o(spi_sclk_i), .spi_cs_n_o(spi_cs_n_i),
		.spi_mosi_o(spi_mosi_i), .spi_miso_i(spi_miso_o),
		.spi_miso_oe_n_i(spi_miso_oe_n_o));
	sfeg_erase_guard #(.BLOCK_ERASE_CYCLES(BLK), .CHIP_ERASE_CYCLES(CHP)) uut (
		.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
		.spi_sclk_i(spi_sclk_i), .spi_cs_n_i(spi_cs_n_i),
		.spi_mosi_i(spi_mosi_i), .spi_miso_o(spi_miso_o),
		.spi_miso_oe_n_o(spi_miso_oe_n_o), .erase_start_o(erase_start_o),
		.erase_req_o(erase_req_o), .erase_fill_o(erase_fill_o),
		.verify_valid_i(verify_valid_i), .verify_data_i(verify_data_i),
		.busy_o(busy_o), .write_latch_flag_o(write_latch_flag_o),
		.erase_program_error_flag_o(erase_program_error_flag_o),
		.sector_prot_o(sector_prot_o), .seq_prog_exit_o(seq_prog_exit_o));
	always @(posedge core_clk_i) begin
		if (erase_start_o === 1'b1) begin
			starts++;
			last_req = erase_req_o;
		end
		if (seq_prog_exit_o === 1'b1) exits++;
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : report_and_stop
	task automatic do_reset();
		@(posedge core_clk_i) reset_n_i <= 1'b0;
		repeat (8) @(posedge core_clk_i);
		reset_n_i <= 1'b1;
		repeat (3) @(posedge core_clk_i);
	endtask : do_reset
	task automatic send(input logic [7:0] op, input logic [23:0] a,
		input int nb);
		logic [7:0] rd;
		host.xfer({op, a, 8'h5a}, nb, rd);
	endtask : send
	task automatic wren();
		send(OP_WR_ENABLE, 24'h0, 8);
	endtask : wren
	task automatic verify(input logic [7:0] v);
		@(posedge core_clk_i);
		verify_valid_i <= 1'b1;
		verify_data_i <= v;
		@(posedge core_clk_i);
		verify_valid_i <= 1'b0;
	endtask : verify
	task automatic wait_idle();
		int i;
		// poll busy instead of sitting out the full erase time
		for (i = 0; i < 2000 && busy_o !== 1'b0; i++) @(posedge core_clk_i);
		`CHK("idle", 1'b0, busy_o)
		if (busy_o !== 1'b0) report_and_stop();
	endtask : wait_idle
	task automatic try_erase(input logic [7:0] op, input logic [23:0] a,
		input logic ok, input sfeg_size_type sz, input logic [18:0] base,
		input logic [7:0] v);
		int n;
		logic [7:0] rd;
		n = starts;
		wren();
		send(op, a, 40);
		`CHK("start", ok, starts == n + 1)
		`CHK("wlf", 1'b0, write_latch_flag_o)
		if (ok) begin
			`CHK("size", sz, last_req.size)
			`CHK("base", base, last_req.base)
			host.xfer({OP_READ_STATUS, 32'h0}, 16, rd);
			`CHK("busy bit", 1'b1, rd[STAT_BUSY])
			wren();
			`CHK("wlf busy", 1'b0, write_latch_flag_o)
			verify(v);
			wait_idle();
			`CHK("epe", v != ERASED_BYTE, erase_program_error_flag_o)
		end
	endtask : try_erase

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		`CHK("prot", {NUM_SECT{1'b1}}, sector_prot_o)
		`CHK("wlf", 1'b0, write_latch_flag_o)
		`CHK("fill", ERASED_BYTE, erase_fill_o)
		$display("test reset done");
	endtask : t_reset
	task automatic t_latch();
		send(OP_WR_ENABLE, 24'h0, 16);
		`CHK("wlf set", 1'b1, write_latch_flag_o)
		send(OP_WR_DISABLE, 24'h0, 12);
		`CHK("wlf kept", 1'b1, write_latch_flag_o)
		send(OP_WR_DISABLE, 24'h0, 8);
		`CHK("wlf clr", 1'b0, write_latch_flag_o)
		`CHK("exits", 1, exits)
		send(OP_WR_ENABLE, 24'h0, 5);
		`CHK("wlf short", 1'b0, write_latch_flag_o)
		$display("test latch done");
	endtask : t_latch
	task automatic t_guard();
		send(OP_UNPROTECT, 24'h0, 32);
		`CHK("prot0", 1'b1, sector_prot_o[0])
		try_erase(OP_ERASE_4K, 24'h000abc, 1'b0, SZ_4K, 19'h0, 8'hff);
		wren();
		send(OP_UNPROTECT, 24'h00f000, 32);
		`CHK("prot0", 1'b0, sector_prot_o[0])
		`CHK("wlf", 1'b0, write_latch_flag_o)
		wren();
		send(OP_ERASE_4K, 24'h000abc, 28);
		`CHK("wlf", 1'b0, write_latch_flag_o)
		wren();
		send(OP_ERASE_4K, 24'h000abc, 24);
		`CHK("starts", 0, starts)
		$display("test guard done");
	endtask : t_guard
	task automatic t_block();
		try_erase(OP_ERASE_4K, 24'h00fabc, 1'b1, SZ_4K, 19'h0f000, 8'hff);
		try_erase(OP_ERASE_32K, 24'h00ffff, 1'b1, SZ_32K, 19'h08000, 8'h00);
		try_erase(OP_ERASE_64K, 24'h00ffff, 1'b1, SZ_64K, 19'h0, 8'hff);
		$display("test block done");
	endtask : t_block
	task automatic t_span();
		try_erase(OP_ERASE_32K, 24'h074321, 1'b0, SZ_4K, 19'h0, 8'hff);
		wren();
		send(OP_UNPROTECT, 24'h070000, 32);
		try_erase(OP_ERASE_64K, 24'h071234, 1'b0, SZ_4K, 19'h0, 8'hff);
		try_erase(OP_ERASE_32K, 24'h075678, 1'b1, SZ_32K, 19'h70000, 8'hff);
		$display("test span done");
	endtask : t_span
	task automatic t_chip();
		int n;
		try_erase(OP_CHIP_A, 24'h0, 1'b0, SZ_4K, 19'h0, 8'hff);
		for (int s = 0; s < NUM_SECT; s++) begin
			wren();
			send(OP_UNPROTECT, {5'h0, SECT_EDGE[s][18:0]}, 32);
		end
		`CHK("all open", {NUM_SECT{1'b0}}, sector_prot_o)
		n = starts;
		wren();
		send(OP_CHIP_B, 24'h0, 7);
		`CHK("no chip", n, starts)
		try_erase(OP_CHIP_A, 24'h0, 1'b1, SZ_CHIP, 19'h0, 8'hff);
		try_erase(OP_CHIP_B, 24'h0, 1'b1, SZ_CHIP, 19'h0, 8'hff);
		wren();
		send(OP_PROTECT, 24'h07c123, 40);
		`CHK("prot10", 1'b1, sector_prot_o[10])
		`CHK("wlf", 1'b0, write_latch_flag_o)
		$display("test chip done");
	endtask : t_chip

	initial begin
		reset_n_i = 1'b0;
		verify_valid_i = 1'b0;
		verify_data_i = 8'h00;
		do_reset();
		t_reset();
		t_latch();
		t_guard();
		t_block();
		t_span();
		t_chip();
		do_reset();
		t_reset();
		report_and_stop();
	end
endmodule : sfeg_erase_guard_bench
